// file: design/obc_delay_timer.sv
// Reset and halt-exit delay counter for the option byte decoder.
// Assumes load and start are single-cycle pulses on clk_in.
`timescale 1ns/100ps
module obc_delay_timer
  import obc_pkg::*;
#(
  parameter int LONG_CYC  = OBC_RST_LONG_CYC,
  parameter int SHORT_CYC = OBC_RST_SHORT_CYC,
  parameter int CNT_W     = OBC_CNT_W
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic load_in,
  input  wire logic start_in,
  input  wire logic long_sel_in,
  output logic      busy_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             busy_reg;
  logic             busy_next;

  // Load restarts always, start only when idle
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (load_in || (start_in && !busy_reg)) begin
      cnt_next  = long_sel_in ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
  end

  // Held busy from reset until the first load completes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_out = busy_reg;
endmodule // obc_delay_timer

// file: design/obc_option_decoder.sv
// Option byte store, programming port and run-time decoder.
// Assumes prog_mode_in is an asynchronous pin; other inputs are on clk_in.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
module obc_option_decoder
  import obc_pkg::*;
#(
  parameter logic [OBC_PADS-1:0] UNBONDED_PKG0 = 8'h00,
  parameter logic [OBC_PADS-1:0] UNBONDED_PACKAGE_SELECT = 8'h00,
  parameter int                  LONG_CYC      = OBC_RST_LONG_CYC,
  parameter int                  SHORT_CYC     = OBC_RST_SHORT_CYC
) (
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  input  wire logic                     prog_mode_in,
  input  wire logic [obc_pkg::OBC_ADDR_W-1:0] addr_in,
  input  wire logic [obc_pkg::OBC_DATA_W-1:0] wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  input  wire logic                     halt_enter_in,
  input  wire logic                     halt_exit_in,
  input  wire logic                     watchdog_running_in,
  output logic [obc_pkg::OBC_DATA_W-1:0] rdata_out,
  output logic                          watchdog_reset_on_halt_out,
  output logic                          watchdog_soft_enable_sel_out,
  output logic                          watchdog_hw_enable_out,
  output logic                          watchdog_reset_on_halt_reset_out,
  output logic                          readout_protect_n_out,
  output logic                          readout_block_out,
  output logic                          flash_erase_all_out,
  output logic                          erase_busy_out,
  output logic                          package_select_out,
  output logic [obc_pkg::OBC_PADS-1:0]  unbonded_pullup_out,
  output logic                          reset_delay_select_out,
  output logic                          core_reset_hold_out,
  output logic [1:0]                    clock_source_type_out,
  output logic                          resonator_sel_out,
  output logic                          ext_clock_sel_out,
  output logic                          osc_type_reserved_out,
  output logic [2:0]                    oscillator_freq_range_out,
  output logic [obc_pkg::OBC_RANGE_CNT-1:0] resonator_drive_out,
  output logic [obc_pkg::OBC_RANGE_CNT-1:0] op_freq_range_out,
  output logic                          range_reserved_out,
  output logic                          pll_double_en_out,
  output logic                          pll_config_invalid_out
);
  import obc_pkg::*;

  // Programming mode pin synchroniser
  logic ps_meta_reg;
  logic ps_sync_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ps_meta_reg <= 1'b0;
      ps_sync_reg <= 1'b0;
    end else begin
      ps_meta_reg <= prog_mode_in;
      ps_sync_reg <= ps_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // Option byte store and programming port
  // ------------------------------------------------------------------
  logic [7:0]        opt0_reg;
  logic [7:0]        opt0_next;
  logic [7:0]        opt1_reg;
  logic [7:0]        opt1_next;
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;
  logic              erase_pulse_reg;
  logic              erase_pulse_next;
  logic              erase_busy_reg;
  logic              erase_busy_next;
  obc_erase_state_t  est_reg;
  obc_erase_state_t  est_next;
  logic              stored_protect;

  assign stored_protect = !opt0_reg[OBC_B0_RDP_N];

  // Port decode, writes and the erase sequence
  always_comb begin
    opt0_next        = opt0_reg;
    opt1_next        = opt1_reg;
    rdata_next       = OBC_RD_ZERO;
    est_next         = est_reg;
    if (rd_in && ps_sync_reg) begin
      case (addr_in)
        OBC_ADDR_OPT0:  rdata_next = opt0_reg;
        OBC_ADDR_OPT1:  rdata_next = opt1_reg;
        OBC_ADDR_ERASE: rdata_next = {7'h00, erase_busy_reg};
        default:        rdata_next = OBC_RD_ZERO;
      endcase
    end
    case (est_reg)
      OBC_IDLE: begin
        if (wr_in && ps_sync_reg) begin
          if (addr_in == OBC_ADDR_ERASE) begin
            if (stored_protect) begin
              est_next = OBC_WIPE_USER;
            end else begin
              opt0_next = OBC_ERASED;
              opt1_next = OBC_ERASED;
            end
          end else if (!stored_protect) begin
            if (addr_in == OBC_ADDR_OPT0) begin
              opt0_next = wdata_in;
            end else if (addr_in == OBC_ADDR_OPT1) begin
              opt1_next = wdata_in;
            end
          end
        end
      end
      OBC_WIPE_USER: est_next = OBC_WIPE_OPT;
      OBC_WIPE_OPT: begin
        opt0_next = OBC_ERASED;
        opt1_next = OBC_ERASED;
        est_next  = OBC_IDLE;
      end
      default: est_next = OBC_IDLE;
    endcase
    erase_pulse_next = (est_next == OBC_WIPE_USER);
    erase_busy_next  = (est_next != OBC_IDLE);
  end

  // Store starts as delivered flash, all ones
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      opt0_reg        <= OBC_ERASED;
      opt1_reg        <= OBC_ERASED;
      rdata_reg       <= OBC_RD_ZERO;
      est_reg         <= OBC_IDLE;
      erase_pulse_reg <= 1'b0;
      erase_busy_reg  <= 1'b0;
    end else begin
      opt0_reg        <= opt0_next;
      opt1_reg        <= opt1_next;
      rdata_reg       <= rdata_next;
      est_reg         <= est_next;
      erase_pulse_reg <= erase_pulse_next;
      erase_busy_reg  <= erase_busy_next;
    end
  end

  assign rdata_out           = rdata_reg;
  assign flash_erase_all_out = erase_pulse_reg;
  assign erase_busy_out      = erase_busy_reg;

  // ------------------------------------------------------------------
  // Decoded run-time controls, captured once after reset release, except the per-cycle halt-entry reset
  // ------------------------------------------------------------------
  logic                  loaded_reg;
  logic                  wrh_reg,  wrh_next;
  logic                  wsw_reg,  wsw_next;
  logic                  rdpn_reg, rdpn_next;
  logic                  pkg_reg,  pkg_next;
  logic [OBC_PADS-1:0]   pull_reg, pull_next;
  logic                  reset_delay_select_reg, reset_delay_select_next;
  logic [1:0]            osc_reg,  osc_next;
  logic [2:0]            rng_reg,  rng_next;
  logic [OBC_RANGE_CNT-1:0] drv_reg, drv_next;
  logic [OBC_RANGE_CNT-1:0] opr_reg, opr_next;
  logic                  pll_reg,  pll_next;
  logic                  whr_reg,  whr_next;
  logic [OBC_RANGE_CNT-1:0] rng_hot;
  logic [2:0]            rng_raw;

  assign rng_raw = opt1_reg[OBC_B1_RNG_HI:OBC_B1_RNG_LO];

  // One-hot range decode, one lane per documented range
  genvar gi;
  generate
    for (gi = 0; gi < OBC_RANGE_CNT; gi++) begin : g_rng
      assign rng_hot[gi] = (rng_raw == 3'(gi));
    end
  endgenerate

  // Decode on the first cycle after release, then hold; the halt-entry reset is computed every cycle
  always_comb begin
    wrh_next  = wrh_reg;
    wsw_next  = wsw_reg;
    rdpn_next = rdpn_reg;
    pkg_next  = pkg_reg;
    pull_next = pull_reg;
    reset_delay_select_next = reset_delay_select_reg;
    osc_next  = osc_reg;
    rng_next  = rng_reg;
    drv_next  = drv_reg;
    opr_next  = opr_reg;
    pll_next  = pll_reg;
    if (!loaded_reg) begin
      wrh_next  = opt0_reg[OBC_B0_WATCHDOG_RESET_ON_HALT];
      wsw_next  = opt0_reg[OBC_B0_WATCHDOG_SOFT_ENABLE_SEL];
      rdpn_next = opt0_reg[OBC_B0_RDP_N];
      pkg_next  = opt1_reg[OBC_B1_PKG];
      pull_next = opt1_reg[OBC_B1_PKG] ? UNBONDED_PACKAGE_SELECT : UNBONDED_PKG0;
      reset_delay_select_next = opt1_reg[OBC_B1_RESET_DELAY_SELECT];
      osc_next  = opt1_reg[OBC_B1_OSC_HI:OBC_B1_OSC_LO];
      rng_next  = rng_raw;
      if (opt1_reg[OBC_B1_OSC_HI:OBC_B1_OSC_LO] == OBC_OSC_RESONATOR) begin
        drv_next = rng_hot;
        opr_next = '0;
      end else begin
        drv_next = '0;
        opr_next = rng_hot;
      end
      pll_next  = !opt1_reg[OBC_B1_PLL_OFF];
    end
    whr_next = loaded_reg && wrh_reg && halt_enter_in && watchdog_running_in;
  end

  // Reset values mirror an erased store
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      loaded_reg <= 1'b0;
      wrh_reg    <= OBC_ERASED[OBC_B0_WATCHDOG_RESET_ON_HALT];
      wsw_reg    <= OBC_ERASED[OBC_B0_WATCHDOG_SOFT_ENABLE_SEL];
      rdpn_reg   <= OBC_ERASED[OBC_B0_RDP_N];
      pkg_reg    <= OBC_ERASED[OBC_B1_PKG];
      pull_reg   <= UNBONDED_PACKAGE_SELECT;
      reset_delay_select_reg   <= OBC_ERASED[OBC_B1_RESET_DELAY_SELECT];
      osc_reg    <= OBC_ERASED[OBC_B1_OSC_HI:OBC_B1_OSC_LO];
      rng_reg    <= OBC_ERASED[OBC_B1_RNG_HI:OBC_B1_RNG_LO];
      drv_reg    <= '0;
      opr_reg    <= '0;
      pll_reg    <= !OBC_ERASED[OBC_B1_PLL_OFF];
      whr_reg    <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
      wrh_reg    <= wrh_next;
      wsw_reg    <= wsw_next;
      rdpn_reg   <= rdpn_next;
      pkg_reg    <= pkg_next;
      pull_reg   <= pull_next;
      reset_delay_select_reg   <= reset_delay_select_next;
      osc_reg    <= osc_next;
      rng_reg    <= rng_next;
      drv_reg    <= drv_next;
      opr_reg    <= opr_next;
      pll_reg    <= pll_next;
      whr_reg    <= whr_next;
    end
  end

  // Status flags derived from captured fields
  logic hwen_reg, prot_reg, ext_reg, res_reg, ores_reg, rres_reg, pbad_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hwen_reg <= 1'b0;
      prot_reg <= 1'b0;
      ext_reg  <= 1'b0;
      res_reg  <= 1'b0;
      ores_reg <= 1'b0;
      rres_reg <= 1'b0;
      pbad_reg <= 1'b0;
    end else begin
      hwen_reg <= !wsw_next;
      prot_reg <= !rdpn_next;
      ext_reg  <= (osc_next == OBC_OSC_EXTERNAL);
      res_reg  <= (osc_next == OBC_OSC_RESONATOR);
      ores_reg <= (osc_next != OBC_OSC_EXTERNAL) && (osc_next != OBC_OSC_RESONATOR);
      rres_reg <= (rng_next > OBC_RANGE_EIGHT_TO_SIXTEEN_MHZ);
      pbad_reg <= pll_next && (rng_next != OBC_RANGE_TWO_TO_FOUR_MHZ);
    end
  end

  // Reset phase and halt-exit delay
  obc_delay_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC),
    .CNT_W     (OBC_CNT_W)
  ) u_delay (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .load_in     (!loaded_reg),
    .start_in    (loaded_reg && halt_exit_in),
    .long_sel_in (loaded_reg ? !reset_delay_select_reg : !opt1_reg[OBC_B1_RESET_DELAY_SELECT]),
    .busy_out    (core_reset_hold_out)
  );

  assign watchdog_reset_on_halt_out   = wrh_reg;
  assign watchdog_soft_enable_sel_out = wsw_reg;
  assign watchdog_hw_enable_out       = hwen_reg;
  assign watchdog_reset_on_halt_reset_out           = whr_reg;
  assign readout_protect_n_out        = rdpn_reg;
  assign readout_block_out            = prot_reg;
  assign package_select_out           = pkg_reg;
  assign unbonded_pullup_out          = pull_reg;
  assign reset_delay_select_out       = reset_delay_select_reg;
  assign clock_source_type_out        = osc_reg;
  assign resonator_sel_out            = res_reg;
  assign ext_clock_sel_out            = ext_reg;
  assign osc_type_reserved_out        = ores_reg;
  assign oscillator_freq_range_out    = rng_reg;
  assign resonator_drive_out          = drv_reg;
  assign op_freq_range_out            = opr_reg;
  assign range_reserved_out           = rres_reg;
  assign pll_double_en_out            = pll_reg;
  assign pll_config_invalid_out       = pbad_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_NO_READ_OUTSIDE_PROG: assert property (
    rd_in && !ps_sync_reg |=> rdata_out == OBC_RD_ZERO)
    else $error("option byte read outside programming mode");
  AST_READ_OPT1: assert property (
    rd_in && ps_sync_reg && addr_in == OBC_ADDR_OPT1 |=> rdata_out == $past(opt1_reg))
    else $error("second option byte read mismatch");
  AST_HOLD_SESSION: assert property (
    loaded_reg |=> $stable(readout_protect_n_out) && $stable(pll_double_en_out) && $stable(clock_source_type_out))
    else $error("decoded control changed during session");
  AST_WATCHDOG_RESET_ON_HALT_RESET: assert property (
    loaded_reg && watchdog_reset_on_halt_out && halt_enter_in && watchdog_running_in |=> watchdog_reset_on_halt_reset_out)
    else $error("missing reset on halt entry");
  AST_WATCHDOG_RESET_ON_HALT_QUIET: assert property (
    !watchdog_reset_on_halt_out |=> !watchdog_reset_on_halt_reset_out)
    else $error("reset on halt entry while disabled");
  AST_HW_WATCHDOG: assert property (
    loaded_reg |-> watchdog_hw_enable_out == !watchdog_soft_enable_sel_out)
    else $error("watchdog type decode wrong");
  AST_PROTECT: assert property (
    loaded_reg |-> readout_block_out == !readout_protect_n_out)
    else $error("protection decode wrong");
  AST_ERASE_ORDER: assert property (
    est_reg == OBC_IDLE && wr_in && ps_sync_reg && addr_in == OBC_ADDR_ERASE && stored_protect
    |=> flash_erase_all_out ##1 !flash_erase_all_out ##1 (opt0_reg == OBC_ERASED && opt1_reg == OBC_ERASED))
    else $error("user memory not erased before option bytes");
  AST_SHORT_DELAY: assert property (
    loaded_reg && reset_delay_select_out && halt_exit_in && !core_reset_hold_out
    |=> core_reset_hold_out ##255 core_reset_hold_out ##1 !core_reset_hold_out)
    else $error("short halt-exit delay length wrong");
  AST_PLL_DECODE: assert property (
    $rose(loaded_reg) |-> pll_double_en_out == !$past(opt1_reg[OBC_B1_PLL_OFF]))
    else $error("PLL enable decode wrong");
  AST_RANGE_SPLIT: assert property (
    loaded_reg |-> (resonator_sel_out ? op_freq_range_out == '0 : resonator_drive_out == '0))
    else $error("range routed to wrong consumer");
  AST_PKG_PADS: assert property (
    loaded_reg && !package_select_out |-> unbonded_pullup_out == UNBONDED_PKG0)
    else $error("unbonded pad pull-up mask wrong");
endmodule // obc_option_decoder

// file: design/obc_pkg.sv
// Constants for the option byte configuration decoder.
// Assumes a single core clock and one active-low asynchronous reset.
package obc_pkg;
  localparam int          OBC_ADDR_W   = 2;
  localparam int          OBC_DATA_W   = 8;
  localparam int          OBC_PADS     = 8;
  // Programming port map
  localparam logic [1:0]  OBC_ADDR_OPT0  = 2'h0;
  localparam logic [1:0]  OBC_ADDR_OPT1  = 2'h1;
  localparam logic [1:0]  OBC_ADDR_ERASE = 2'h2;
  // Erased flash content of each byte
  localparam logic [7:0]  OBC_ERASED   = 8'hff;
  localparam logic [7:0]  OBC_RD_ZERO  = 8'h00;
  // First byte field positions
  localparam int          OBC_B0_WATCHDOG_RESET_ON_HALT = 7;
  localparam int          OBC_B0_WATCHDOG_SOFT_ENABLE_SEL   = 6;
  localparam int          OBC_B0_RDP_N    = 0;
  // Second byte field positions
  localparam int          OBC_B1_PKG      = 7;
  localparam int          OBC_B1_RESET_DELAY_SELECT     = 6;
  localparam int          OBC_B1_OSC_HI   = 5;
  localparam int          OBC_B1_OSC_LO   = 4;
  localparam int          OBC_B1_RNG_HI   = 3;
  localparam int          OBC_B1_RNG_LO   = 1;
  localparam int          OBC_B1_PLL_OFF  = 0;
  // Clock source and range encodings
  localparam logic [1:0]  OBC_OSC_RESONATOR = 2'h0;
  localparam logic [1:0]  OBC_OSC_EXTERNAL  = 2'h3;
  localparam logic [2:0]  OBC_RANGE_ONE_TO_TWO_MHZ     = 3'h0;
  localparam logic [2:0]  OBC_RANGE_TWO_TO_FOUR_MHZ    = 3'h1;
  localparam logic [2:0]  OBC_RANGE_FOUR_TO_EIGHT_MHZ  = 3'h2;
  localparam logic [2:0]  OBC_RANGE_EIGHT_TO_SIXTEEN_MHZ = 3'h3;
  localparam int          OBC_RANGE_CNT = 4;
  // Reset phase lengths in CPU cycles
  localparam int          OBC_RST_LONG_CYC  = 4096;
  localparam int          OBC_RST_SHORT_CYC = 256;
  localparam int          OBC_CNT_W         = 13;
  // Erase sequencer states
  typedef enum logic [1:0] {OBC_IDLE, OBC_WIPE_USER, OBC_WIPE_OPT} obc_erase_state_t;
endpackage

// file: test/obc_prog_tool.sv
// Programming tool model for the option byte port.
// Assumes requests are sampled on the rising clk_in edge.
`timescale 1ns/100ps
module obc_prog_tool
  import obc_pkg::*;
(
  input  wire logic                           clk_in,
  input  wire logic [obc_pkg::OBC_DATA_W-1:0] rdata_in,
  output logic                                prog_mode_out,
  output logic [obc_pkg::OBC_ADDR_W-1:0]      addr_out,
  output logic [obc_pkg::OBC_DATA_W-1:0]      wdata_out,
  output logic                                wr_out,
  output logic                                rd_out
);
  // Idle port, mode off
  initial begin
    prog_mode_out = 1'b0;
    addr_out = 2'h3;
    wdata_out = 8'h5a;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Mode pin change, then wait out the synchroniser
  task automatic set_mode(input logic on);
    @(posedge clk_in);
    prog_mode_out <= on;
    repeat (3) @(posedge clk_in);
  endtask
  // One-cycle write; the idle bus shows inverted values
  task automatic write_byte(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == OBC_ADDR_OPT0) v[5:1] = 5'h13; // Reserved bits at default
    if (a == OBC_ADDR_OPT1 && v[5:4] == OBC_OSC_RESONATOR) v[6] = 1'b0; // Long delay
    if (a == OBC_ADDR_OPT1 && !v[0]) v[3:1] = OBC_RANGE_TWO_TO_FOUR_MHZ; // Doubling at 2-4 MHz
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~v;
  endtask
  // One-cycle read; data taken in the next cycle
  task automatic read_byte(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rdata_in;
  endtask
endmodule // obc_prog_tool

// file: test/test_obc_option_decoder.sv
// Self-checking bench for the option byte decoder.
// Assumes the tool model drives the programming port.
`timescale 1ns/100ps
module test_obc_option_decoder;
  import obc_pkg::*;
  logic       clk_in = 1'b0, rstn_in = 1'b0, halt_enter_in = 1'b0, halt_exit_in = 1'b0;
  logic       watchdog_running_in = 1'b0, prog_mode_in, wr_in, rd_in;
  logic [1:0] addr_in, clock_source_type_out;
  logic [2:0] oscillator_freq_range_out;
  logic [3:0] resonator_drive_out, op_freq_range_out;
  logic [7:0] wdata_in, rdata_out, unbonded_pullup_out, rd_val;
  logic       watchdog_reset_on_halt_out, watchdog_soft_enable_sel_out, watchdog_hw_enable_out;
  logic       watchdog_reset_on_halt_reset_out, readout_protect_n_out, readout_block_out, flash_erase_all_out;
  logic       erase_busy_out, package_select_out, reset_delay_select_out, core_reset_hold_out;
  logic       resonator_sel_out, ext_clock_sel_out, osc_type_reserved_out, range_reserved_out;
  logic       pll_double_en_out, pll_config_invalid_out;
  int         bad_count = 0, samples_checked = 0;
  // Core clock, 5 ns period
  always #2.5 clk_in = ~clk_in;
  obc_option_decoder #(.UNBONDED_PKG0(8'h0f), .UNBONDED_PACKAGE_SELECT(8'hf0)) dut_u (.*);
  obc_prog_tool tool_u (.clk_in(clk_in), .rdata_in(rdata_out), .prog_mode_out(prog_mode_in),
    .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
  // Comparisons
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_n(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Counts cycles with the core held
  task automatic count_hold(input int span, output int n);
    n = 0;
    repeat (span) begin
      #1 if (core_reset_hold_out === 1'b1) n++;
      @(posedge clk_in);
    end
  endtask
  // Decode of blank bytes and reset phase length
  task automatic t_reset_decode;
    int n;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Edge 1 after release loads the controls and the hold counter
    @(posedge clk_in);
    #1;
    check8({watchdog_reset_on_halt_out, watchdog_soft_enable_sel_out, watchdog_hw_enable_out}, 8'h06, "wdg");
    check8({readout_protect_n_out, readout_block_out}, 8'h02, "protect");
    check8({clock_source_type_out, resonator_sel_out, ext_clock_sel_out, osc_type_reserved_out}, 8'h1a, "osc");
    check8({oscillator_freq_range_out, range_reserved_out, resonator_drive_out}, 8'hf0, "range");
    check8({op_freq_range_out, pll_double_en_out, pll_config_invalid_out}, 8'h00, "op pll");
    check8({package_select_out, reset_delay_select_out}, 8'h03, "pkg");
    check8(unbonded_pullup_out, 8'hf0, "pullup");
    count_hold(300, n);
    check_n(n, OBC_RST_SHORT_CYC, "reset hold");
  endtask
  // Mode gating, blank read, programming, held controls
  task automatic t_program;
    tool_u.read_byte(OBC_ADDR_OPT0, rd_val);
    check8(rd_val, 8'h00, "mode off");
    tool_u.write_byte(OBC_ADDR_OPT1, 8'h00);
    tool_u.set_mode(1'b1);
    tool_u.read_byte(OBC_ADDR_OPT1, rd_val);
    check8(rd_val, OBC_ERASED, "blank");
    tool_u.write_byte(OBC_ADDR_OPT0, 8'hff);
    tool_u.write_byte(OBC_ADDR_OPT1, 8'h42);
    tool_u.read_byte(OBC_ADDR_OPT0, rd_val);
    check8(rd_val, 8'he7, "byte0");
    tool_u.read_byte(OBC_ADDR_OPT1, rd_val);
    check8(rd_val, 8'h02, "byte1");
    tool_u.read_byte(2'h3, rd_val);
    check8(rd_val, 8'h00, "unmapped");
    check8({watchdog_reset_on_halt_out, pll_double_en_out, resonator_sel_out, reset_delay_select_out,
      readout_block_out}, 8'h12, "held");
  endtask
  // Protected store refuses writes until the erase
  task automatic t_protect_erase;
    tool_u.write_byte(OBC_ADDR_OPT0, 8'h00);
    tool_u.write_byte(OBC_ADDR_OPT1, 8'hff);
    tool_u.read_byte(OBC_ADDR_OPT1, rd_val);
    check8(rd_val, 8'h02, "refused");
    tool_u.write_byte(OBC_ADDR_ERASE, 8'h00);
    #1 check8({flash_erase_all_out, erase_busy_out}, 8'h03, "erase c1");
    @(posedge clk_in);
    #1 check8({flash_erase_all_out, erase_busy_out}, 8'h01, "erase c2");
    @(posedge clk_in);
    #1 check8({flash_erase_all_out, erase_busy_out}, 8'h00, "erase c3");
    tool_u.read_byte(OBC_ADDR_OPT0, rd_val);
    check8(rd_val, OBC_ERASED, "wiped");
    tool_u.write_byte(OBC_ADDR_OPT1, 8'h01);
    tool_u.read_byte(OBC_ADDR_OPT1, rd_val);
    check8(rd_val, 8'h01, "unprotected");
  endtask
  // Halt exit delay, a repeated exit inside it ignored
  task automatic t_halt_exit;
    int n;
    @(posedge clk_in);
    halt_exit_in <= 1'b1;
    @(posedge clk_in);
    halt_exit_in <= 1'b0;
    fork
      count_hold(300, n);
      begin
        repeat (20) @(posedge clk_in);
        halt_exit_in <= 1'b1;
        @(posedge clk_in);
        halt_exit_in <= 1'b0;
      end
    join
    check_n(n, OBC_RST_SHORT_CYC, "halt exit");
  endtask
  // Halt entry with or without the watchdog running
  task automatic t_halt_reset(input logic run, input int exp);
    int n;
    n = 0;
    watchdog_running_in <= run;
    halt_enter_in <= 1'b1;
    @(posedge clk_in);
    halt_enter_in <= 1'b0;
    repeat (4) begin
      #1 if (watchdog_reset_on_halt_reset_out === 1'b1) n++;
      @(posedge clk_in);
    end
    check_n(n, exp, "halt reset");
  endtask
  // Main sequence
  initial begin
    t_reset_decode;
    $display("reset decode done");
    t_program;
    $display("program done");
    t_protect_erase;
    $display("protect erase done");
    t_halt_exit;
    $display("halt exit done");
    t_halt_reset(1'b1, 1);
    t_halt_reset(1'b0, 0);
    $display("halt done");
    complete_run;
  end
  // Hang guard, about fifteen times the expected run
  initial begin
    #50000;
    bad_count++;
    complete_run;
  end
endmodule // test_obc_option_decoder
